// ===== common/iosm_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef IOSM_DEFS_SVH
`define IOSM_DEFS_SVH
// register byte offsets
`define IOSM_A_IN 8'h00
`define IOSM_A_OUT 8'h04
`define IOSM_A_LINK 8'h08
`define IOSM_A_OPT_IN 8'h0c
`define IOSM_A_OPT_OUT 8'h10
`define IOSM_A_CTRL 8'h14
`define IOSM_A_PWR 8'h18
`define IOSM_A_MOT 8'h1c
`define IOSM_A_SVC 8'h20
`define IOSM_A_REM 8'h24
`define IOSM_A_PK_INT 8'h28
`define IOSM_A_PK_HS 8'h2c
`define IOSM_A_PK_CUR 8'h30
`define IOSM_A_CAP 8'h34
`define IOSM_A_CAP_REF 8'h38
// field positions of the status words
`define IOSM_IN_FORWARD 0
`define IOSM_IN_BACKWARD 1
`define IOSM_IN_GEN_LO 2
`define IOSM_IN_EN 11
`define IOSM_LK_FORWARD 13
`define IOSM_LK_REVERSE 14
`define IOSM_LK_RST 15
`define IOSM_OUT_TR_LO 0
`define IOSM_OUT_AUX 4
`define IOSM_OUT_ALARM 8
`define IOSM_LINK_MASK 16'he9ff
// counter limits and reset values
`define IOSM_PWR_LAST 16'hffff
`define IOSM_MOT_LAST 17'h18696
`define IOSM_SVC_RST 17'h00000
`define IOSM_CAPREF_RST 16'h0000
`define IOSM_CAP_FULL 24'h000064
// axi responses
`define IOSM_RESP_OKAY 2'h0
`define IOSM_RESP_SLVERR 2'h2
// timing: clock rate, one second, one hour
`define IOSM_CLK_MHZ 125
`define IOSM_SEC_US 1000000
`define IOSM_SEC_CYCLES (`IOSM_SEC_US * `IOSM_CLK_MHZ)
`define IOSM_HOUR_S 3600
`endif

// ===== common/iosm_pkg.sv
// shared types of the i/o status and maintenance block
package iosm_pkg;
    typedef logic [15:0] iosm_word_t;
    typedef enum logic [1:0] {
        IOSM_CH_IDLE = 2'b01,
        IOSM_CH_RESP = 2'b10
    } iosm_ch_st_t;
endpackage

// ===== common/iosm_tick_if.sv
// carrier between the top and an hour tick generator
`timescale 1ns/1ps
interface iosm_tick_if;
    logic run;
    logic tick;
    modport gen (input run, output tick);
    modport user (output run, input tick);
endinterface

// ===== logic/iosm_hour_tick.sv
// one-hour tick generator counting while run is high
`timescale 1ns/1ps
`include "iosm_defs.svh"
module iosm_hour_tick #(
    parameter logic [26:0] SEC_CYCLES = 27'(`IOSM_SEC_CYCLES),
    parameter logic [11:0] HOUR_S = 12'(`IOSM_HOUR_S)
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // run and tick
    iosm_tick_if.gen t
);
    localparam logic [26:0] SEC_LAST = SEC_CYCLES - 27'h0000001;
    localparam logic [11:0] HOUR_LAST = HOUR_S - 12'h001;
    logic [26:0] cyc_r, cyc_nxt;
    logic [11:0] sec_r, sec_nxt;
    logic tick_r, tick_nxt;

    // cycles make seconds, seconds make the hour
    always_comb begin
        cyc_nxt = cyc_r;
        sec_nxt = sec_r;
        tick_nxt = 1'b0;
        if (t.run) begin
            if (cyc_r == SEC_LAST) begin
                cyc_nxt = 27'h0000000;
                if (sec_r == HOUR_LAST) begin
                    sec_nxt = 12'h000;
                    tick_nxt = 1'b1;
                end else begin
                    sec_nxt = sec_r + 12'h001;
                end
            end else begin
                cyc_nxt = cyc_r + 27'h0000001;
            end
        end
    end

    // register counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cyc_r <= 27'h0000000;
            sec_r <= 12'h000;
            tick_r <= 1'b0;
        end else if (ce) begin
            cyc_r <= cyc_nxt;
            sec_r <= sec_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign t.tick = tick_r;
endmodule

// ===== logic/iosm_top.sv
// i/o status words and maintenance counters behind an axi4-lite slave
`timescale 1ns/1ps
`include "iosm_defs.svh"
module iosm_top #(
    parameter logic [26:0] SEC_CYCLES = 27'(`IOSM_SEC_CYCLES),
    parameter logic [11:0] HOUR_S = 12'(`IOSM_HOUR_S)
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // terminal inputs, low when shorted
    input wire logic forward_run_input_n,
    input wire logic backward_run_input_n,
    input wire logic [6:0] general_input_n,
    input wire logic drive_permit_input_n,
    // output terminal states
    input wire logic [3:0] transistor_output,
    input wire logic auxiliary_relay_output,
    input wire logic alarm_relay_output,
    // link command word and option card
    input wire logic [15:0] link_cmd_word,
    input wire logic [15:0] option_input,
    input wire logic [7:0] option_output,
    // maintenance measurements
    input wire logic motor_running,
    input wire logic [15:0] internal_temp,
    input wire logic [15:0] heatsink_temp,
    input wire logic [15:0] rms_current,
    input wire logic [15:0] cap_measure,
    // link display
    output logic [15:0] link_leds,
    output logic [15:0] link_hex
);
    iosm_pkg::iosm_word_t in_r, in_nxt, out_r, out_nxt, link_r, link_nxt;
    iosm_pkg::iosm_word_t oin_r, oout_r, leds_r, leds_nxt, hex_r, hex_nxt;
    logic [15:0] pwr_r, pwr_nxt;
    logic [16:0] mot_r, mot_nxt, svc_r, svc_nxt;
    logic [31:0] rem_r, rem_nxt;
    logic [15:0] capref_r, capref_nxt;
    logic [23:0] cap_r, cap_nxt, cap_prod;
    logic ctrl_r, ctrl_nxt;
    logic ptick, mtick;
    logic [15:0] smp [3];
    iosm_pkg::iosm_ch_st_t wr_st_r, wr_st_nxt, rd_st_r, rd_st_nxt;
    logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt;
    logic [7:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt, wm, rdata_r, rdata_nxt, rd_word;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic rd_hit;

    // hour ticks: wall clock and motor running time
    iosm_tick_if pwr_if ();
    iosm_tick_if mot_if ();
    assign pwr_if.run = 1'b1;
    assign mot_if.run = motor_running;
    iosm_hour_tick #(.SEC_CYCLES(SEC_CYCLES), .HOUR_S(HOUR_S)) u_pwr_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .t(pwr_if.gen)
    );
    iosm_hour_tick #(.SEC_CYCLES(SEC_CYCLES), .HOUR_S(HOUR_S)) u_mot_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .t(mot_if.gen)
    );
    assign ptick = pwr_if.tick;
    assign mtick = mot_if.tick;

    // pack terminal and link status words and the link display words
    always_comb begin
        in_nxt = 16'h0000;
        in_nxt[`IOSM_IN_FORWARD] = ~forward_run_input_n;
        in_nxt[`IOSM_IN_BACKWARD] = ~backward_run_input_n;
        in_nxt[`IOSM_IN_GEN_LO +: 7] = ~general_input_n;
        in_nxt[`IOSM_IN_EN] = ~drive_permit_input_n;
        out_nxt = 16'h0000;
        out_nxt[`IOSM_OUT_TR_LO +: 4] = transistor_output;
        out_nxt[`IOSM_OUT_AUX] = auxiliary_relay_output;
        out_nxt[`IOSM_OUT_ALARM] = alarm_relay_output;
        link_nxt = link_cmd_word & `IOSM_LINK_MASK;
        leds_nxt = ctrl_r ? 16'h0000 : link_r;
        hex_nxt = ctrl_r ? link_r : 16'h0000;
    end

    // register status words
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_r <= 16'h0000;
            out_r <= 16'h0000;
            link_r <= 16'h0000;
            oin_r <= 16'h0000;
            oout_r <= 16'h0000;
            leds_r <= 16'h0000;
            hex_r <= 16'h0000;
        end else if (ce) begin
            in_r <= in_nxt;
            out_r <= out_nxt;
            link_r <= link_nxt;
            oin_r <= option_input;
            oout_r <= {8'h00, option_output};
            leds_r <= leds_nxt;
            hex_r <= hex_nxt;
        end
    end
    assign link_leds = leds_r;
    assign link_hex = hex_r;

    // hour counters, service remaining, capacitor health
    always_comb begin
        pwr_nxt = pwr_r;
        mot_nxt = mot_r;
        if (ptick) begin
            pwr_nxt = pwr_r + 16'h0001;
        end
        if (mtick) begin
            if (mot_r == `IOSM_MOT_LAST) begin
                mot_nxt = 17'h00000;
            end else begin
                mot_nxt = mot_r + 17'h00001;
            end
        end
        rem_nxt = {15'h0000, svc_r} - {15'h0000, mot_r};
        cap_prod = 24'(cap_measure) * `IOSM_CAP_FULL;
        if (capref_r == 16'h0000) begin
            cap_nxt = 24'h000000;
        end else begin
            cap_nxt = cap_prod / {8'h00, capref_r};
        end
    end

    // register maintenance values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr_r <= 16'h0000;
            mot_r <= 17'h00000;
            rem_r <= 32'h00000000;
            cap_r <= 24'h000000;
        end else if (ce) begin
            pwr_r <= pwr_nxt;
            mot_r <= mot_nxt;
            rem_r <= rem_nxt;
            cap_r <= cap_nxt;
        end
    end

    // hourly peak trackers, one each for internal_temp, heatsink_temp and rms_current
    assign smp[0] = internal_temp;
    assign smp[1] = heatsink_temp;
    assign smp[2] = rms_current;
    for (genvar g = 0; g < 3; g++) begin : g_peak
        logic [15:0] cur_r, cur_nxt, rep_r, rep_nxt;
        always_comb begin
            cur_nxt = cur_r;
            rep_nxt = rep_r;
            if (ptick) begin
                rep_nxt = (smp[g] > cur_r) ? smp[g] : cur_r;
                cur_nxt = 16'h0000;
            end else if (smp[g] > cur_r) begin
                cur_nxt = smp[g];
            end
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cur_r <= 16'h0000;
                rep_r <= 16'h0000;
            end else if (ce) begin
                cur_r <= cur_nxt;
                rep_r <= rep_nxt;
            end
        end
    end

    // byte-lane mask from the write strobes
    always_comb begin
        wm = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            wm[8*i +: 8] = wstrb_r[i] ? 8'hff : 8'h00;
        end
    end

    // axi write channel and writable registers
    always_comb begin
        wr_st_nxt = wr_st_r;
        aw_ok_nxt = aw_ok_r;
        awaddr_nxt = awaddr_r;
        w_ok_nxt = w_ok_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bresp_nxt = bresp_r;
        ctrl_nxt = ctrl_r;
        svc_nxt = svc_r;
        capref_nxt = capref_r;
        case (wr_st_r)
            iosm_pkg::IOSM_CH_IDLE: begin
                if (awvalid && awready) begin
                    aw_ok_nxt = 1'b1;
                    awaddr_nxt = awaddr;
                end
                if (wvalid && wready) begin
                    w_ok_nxt = 1'b1;
                    wdata_nxt = wdata;
                    wstrb_nxt = wstrb;
                end
                if (aw_ok_r && w_ok_r) begin
                    aw_ok_nxt = 1'b0;
                    w_ok_nxt = 1'b0;
                    wr_st_nxt = iosm_pkg::IOSM_CH_RESP;
                    bresp_nxt = `IOSM_RESP_OKAY;
                    case (awaddr_r)
                        `IOSM_A_CTRL: begin
                            if (wstrb_r[0]) begin
                                ctrl_nxt = wdata_r[0];
                            end
                        end
                        `IOSM_A_SVC: begin
                            svc_nxt = 17'(({15'h0000, svc_r} & ~wm) |
                                          (wdata_r & wm));
                        end
                        `IOSM_A_CAP_REF: begin
                            capref_nxt = 16'(({16'h0000, capref_r} & ~wm) |
                                             (wdata_r & wm));
                        end
                        `IOSM_A_IN, `IOSM_A_OUT, `IOSM_A_LINK,
                        `IOSM_A_OPT_IN, `IOSM_A_OPT_OUT, `IOSM_A_PWR,
                        `IOSM_A_MOT, `IOSM_A_REM, `IOSM_A_PK_INT,
                        `IOSM_A_PK_HS, `IOSM_A_PK_CUR, `IOSM_A_CAP: begin
                            bresp_nxt = `IOSM_RESP_OKAY; // read only
                        end
                        default: bresp_nxt = `IOSM_RESP_SLVERR;
                    endcase
                end
            end
            iosm_pkg::IOSM_CH_RESP: begin
                if (bready) begin
                    wr_st_nxt = iosm_pkg::IOSM_CH_IDLE;
                end
            end
            default: wr_st_nxt = iosm_pkg::IOSM_CH_IDLE;
        endcase
    end

    // register write channel state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_st_r <= iosm_pkg::IOSM_CH_IDLE;
            aw_ok_r <= 1'b0;
            awaddr_r <= 8'h00;
            w_ok_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            bresp_r <= `IOSM_RESP_OKAY;
            ctrl_r <= 1'b0;
            svc_r <= `IOSM_SVC_RST;
            capref_r <= `IOSM_CAPREF_RST;
        end else if (ce) begin
            wr_st_r <= wr_st_nxt;
            aw_ok_r <= aw_ok_nxt;
            awaddr_r <= awaddr_nxt;
            w_ok_r <= w_ok_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bresp_r <= bresp_nxt;
            ctrl_r <= ctrl_nxt;
            svc_r <= svc_nxt;
            capref_r <= capref_nxt;
        end
    end
    assign awready = ce && (wr_st_r == iosm_pkg::IOSM_CH_IDLE) && !aw_ok_r;
    assign wready = ce && (wr_st_r == iosm_pkg::IOSM_CH_IDLE) && !w_ok_r;
    assign bvalid = (wr_st_r == iosm_pkg::IOSM_CH_RESP);
    assign bresp = bresp_r;

    // read address decode
    always_comb begin
        rd_hit = 1'b1;
        case (araddr)
            `IOSM_A_IN: rd_word = {16'h0000, in_r};
            `IOSM_A_OUT: rd_word = {16'h0000, out_r};
            `IOSM_A_LINK: rd_word = {16'h0000, link_r};
            `IOSM_A_OPT_IN: rd_word = {16'h0000, oin_r};
            `IOSM_A_OPT_OUT: rd_word = {16'h0000, oout_r};
            `IOSM_A_CTRL: rd_word = {31'h00000000, ctrl_r};
            `IOSM_A_PWR: rd_word = {16'h0000, pwr_r};
            `IOSM_A_MOT: rd_word = {15'h0000, mot_r};
            `IOSM_A_SVC: rd_word = {15'h0000, svc_r};
            `IOSM_A_REM: rd_word = rem_r;
            `IOSM_A_PK_INT: rd_word = {16'h0000, g_peak[0].rep_r};
            `IOSM_A_PK_HS: rd_word = {16'h0000, g_peak[1].rep_r};
            `IOSM_A_PK_CUR: rd_word = {16'h0000, g_peak[2].rep_r};
            `IOSM_A_CAP: rd_word = {8'h00, cap_r};
            `IOSM_A_CAP_REF: rd_word = {16'h0000, capref_r};
            default: begin
                rd_word = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // axi read channel
    always_comb begin
        rd_st_nxt = rd_st_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        case (rd_st_r)
            iosm_pkg::IOSM_CH_IDLE: begin
                if (arvalid && arready) begin
                    rd_st_nxt = iosm_pkg::IOSM_CH_RESP;
                    rdata_nxt = rd_word;
                    rresp_nxt = rd_hit ? `IOSM_RESP_OKAY : `IOSM_RESP_SLVERR;
                end
            end
            iosm_pkg::IOSM_CH_RESP: begin
                if (rready) begin
                    rd_st_nxt = iosm_pkg::IOSM_CH_IDLE;
                end
            end
            default: rd_st_nxt = iosm_pkg::IOSM_CH_IDLE;
        endcase
    end

    // register read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_st_r <= iosm_pkg::IOSM_CH_IDLE;
            rdata_r <= 32'h00000000;
            rresp_r <= `IOSM_RESP_OKAY;
        end else if (ce) begin
            rd_st_r <= rd_st_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end
    assign arready = ce && (rd_st_r == iosm_pkg::IOSM_CH_IDLE);
    assign rvalid = (rd_st_r == iosm_pkg::IOSM_CH_RESP);
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    // checks armed from the second edge after reset release
    logic arm_r, arm_nxt;
    always_comb begin
        arm_nxt = aresetn;
    end
    always_ff @(posedge aclk) begin
        arm_r <= arm_nxt;
    end

    // checks on the status words, counters and write response
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !arm_r);
    a_unused_zero: assert property ((in_r & 16'hf600) == 16'h0000 &&
        (out_r & 16'hfee0) == 16'h0000)
        else $error("unassigned status bits not zero");
    a_in_map: assert property (ce |=> in_r[11:0] ==
        {~$past(drive_permit_input_n), 2'b00, ~$past(general_input_n),
         ~$past(backward_run_input_n), ~$past(forward_run_input_n)})
        else $error("input word mapping wrong");
    a_out_tr: assert property (ce |=>
        out_r[3:0] == $past(transistor_output))
        else $error("transistor output bits wrong");
    a_out_aux: assert property (ce |=>
        out_r[4] == $past(auxiliary_relay_output))
        else $error("auxiliary relay bit wrong");
    a_out_alarm: assert property (ce && alarm_relay_output |=>
        out_r[8])
        else $error("alarm relay bit wrong");
    a_link_cmd: assert property (ce |=>
        link_r[15:13] == $past(link_cmd_word[15:13]))
        else $error("link command bits wrong");
    a_link_direct: assert property (ce |=>
        link_r == ($past(link_cmd_word) & `IOSM_LINK_MASK))
        else $error("link word inverted or misplaced");
    a_link_view: assert property (ce && !ctrl_r |=>
        hex_r == 16'h0000 && leds_r == $past(link_r))
        else $error("link view mode wrong");
    a_opt_in: assert property (ce |=> oin_r == $past(option_input))
        else $error("option input word wrong");
    a_opt_out: assert property (ce |=>
        oout_r == {8'h00, $past(option_output)})
        else $error("option output word wrong");
    a_pwr_wrap: assert property (ce && ptick &&
        pwr_r == `IOSM_PWR_LAST |=> pwr_r == 16'h0000)
        else $error("power hours did not wrap");
    a_mot_wrap: assert property (ce && mtick &&
        mot_r == `IOSM_MOT_LAST |=> mot_r == 17'h00000)
        else $error("motor hours did not wrap");
    a_mot_bound: assert property (mot_r <= `IOSM_MOT_LAST)
        else $error("motor hours beyond limit");
    a_svc_remain: assert property (ce |=>
        rem_r == {15'h0000, $past(svc_r)} - {15'h0000, $past(mot_r)})
        else $error("remaining service time wrong");
    a_peak_restart: assert property (ce && ptick |=>
        g_peak[0].cur_r == 16'h0000 &&
        g_peak[0].rep_r >= $past(g_peak[0].cur_r))
        else $error("hourly peak not reported or restarted");
    a_cap_full: assert property (ce && capref_r != 16'h0000 &&
        cap_measure == capref_r |=> cap_r == `IOSM_CAP_FULL)
        else $error("full capacitance not 100 percent");
    a_tick_single: assert property (ptick && ce |=> !ptick)
        else $error("hour tick longer than one cycle");
    a_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped");
    c_write: cover property (bvalid && bready);
    c_read: cover property (rvalid && rready && rresp == `IOSM_RESP_OKAY);
    c_pwr_tick: cover property (ce && ptick);
    c_hex_view: cover property (ce && ctrl_r && hex_r != 16'h0000);
endmodule

// ===== tb/iosm_tb_top.sv
// self-checking bench for the i/o status and maintenance block
`timescale 1ns/1ps
`include "iosm_defs.svh"
module iosm_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, v0, v1, m0;
    logic fw_n = 1'b0, bwd_n = 1'b1, permit_n = 1'b0;
    logic [6:0] gen_n = 7'h00;
    logic [3:0] tr_out = 4'h9;
    logic aux = 1'b1, alarm = 1'b1, motor = 1'b1;
    logic [15:0] link_w = 16'hffff, opt_in = 16'h8001;
    logic [7:0] opt_out = 8'h81;
    logic [15:0] t_int = 16'h0123, t_hs = 16'h0456, i_rms = 16'h0789;
    logic [15:0] cap_m = 16'h0096, leds, hexw;
    int n_fail = 0, checked = 0, cyc = 0, c0;

    // 125 MHz clock and a free cycle count
    always #4 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;

    // hour tick every 12 cycles
    iosm_top #(.SEC_CYCLES(27'h0000004), .HOUR_S(12'h003)) iosm_top_i (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .forward_run_input_n(fw_n), .backward_run_input_n(bwd_n),
        .general_input_n(gen_n), .drive_permit_input_n(permit_n),
        .transistor_output(tr_out), .auxiliary_relay_output(aux),
        .alarm_relay_output(alarm), .link_cmd_word(link_w),
        .option_input(opt_in), .option_output(opt_out),
        .motor_running(motor), .internal_temp(t_int),
        .heatsink_temp(t_hs), .rms_current(i_rms), .cap_measure(cap_m),
        .link_leds(leds), .link_hex(hexw)
    );

    // verdict and end of run
    task automatic complete_run();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // compare one value
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask

    // a wait that used up its bound ends the run
    task automatic wait_ok(input logic done);
        if (!done) begin
            chk("handshake", 32'h1, 32'h0);
            complete_run();
        end
    endtask

    // axi4-lite write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int n;
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        tb = 1'b0;
        while (!tb && n < 40) begin
            @(negedge aclk);
            ta = awvalid && awready === 1'b1;
            tw = wvalid && wready === 1'b1;
            tb = bvalid === 1'b1;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        wait_ok(tb);
    endtask

    // axi4-lite read
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        tr = 1'b0;
        while (!tr && n < 40) begin
            @(negedge aclk);
            ta = arvalid && arready === 1'b1;
            tr = rvalid === 1'b1;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        wait_ok(tr);
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`IOSM_A_IN, v0, rs);
        chk("in word", 32'h000009fd, v0);
        rd(`IOSM_A_OUT, v0, rs);
        chk("out word", 32'h00000119, v0);
        rd(`IOSM_A_LINK, v0, rs);
        chk("link word", 32'h0000e9ff, v0);
        rd(`IOSM_A_OPT_IN, v0, rs);
        chk("option in", 32'h00008001, v0);
        rd(`IOSM_A_OPT_OUT, v0, rs);
        chk("option out", 32'h00000081, v0);
        chk("leds", 32'h0000e9ff, {16'h0, leds});
        chk("hex", 32'h0, {16'h0, hexw});
        wr(`IOSM_A_CTRL, 32'h1, rs);
        chk("ctrl write resp", 32'h0, {30'h0, rs});
        rd(`IOSM_A_CTRL, v0, rs);
        chk("ctrl readback", 32'h1, v0);
        chk("leds hex mode", 32'h0, {16'h0, leds});
        chk("hex hex mode", 32'h0000e9ff, {16'h0, hexw});
        rd(8'h3c, v0, rs);
        chk("unmapped read resp", 32'h2, {30'h0, rs});
        chk("unmapped read data", 32'h0, v0);
        wr(8'h15, 32'h1, rs);
        chk("unaligned write resp", 32'h2, {30'h0, rs});
        wr(`IOSM_A_IN, 32'h0, rs);
        chk("read-only write resp", 32'h0, {30'h0, rs});
        rd(`IOSM_A_IN, v0, rs);
        chk("read-only write", 32'h000009fd, v0);
        // two snapshots exactly one hour apart
        c0 = cyc;
        rd(`IOSM_A_PWR, v0, rs);
        rd(`IOSM_A_MOT, m0, rs);
        while (cyc < c0 + 12) @(posedge aclk);
        rd(`IOSM_A_PWR, v1, rs);
        chk("power hours step", v0 + 32'h1, v1);
        rd(`IOSM_A_MOT, v1, rs);
        chk("motor hours step", m0 + 32'h1, v1);
        // clock enable low: 36 cycles span only 12 counted ones
        c0 = cyc;
        rd(`IOSM_A_PWR, v0, rs);
        ce <= 1'b0;
        repeat (24) @(posedge aclk);
        chk("ready while frozen", 32'h0, {29'h0, awready, wready, arready});
        ce <= 1'b1;
        while (cyc < c0 + 36) @(posedge aclk);
        rd(`IOSM_A_PWR, v1, rs);
        chk("power hours frozen", v0 + 32'h1, v1);
        // motor stopped: run hours hold
        motor <= 1'b0;
        rd(`IOSM_A_MOT, m0, rs);
        repeat (30) @(posedge aclk);
        rd(`IOSM_A_MOT, v1, rs);
        chk("motor hours held", m0, v1);
        wr(`IOSM_A_SVC, 32'h64, rs);
        rd(`IOSM_A_REM, v1, rs);
        chk("service remaining", 32'h64 - m0, v1);
        // only byte lane 1 of the interval is written
        wstrb <= 4'h2;
        wr(`IOSM_A_SVC, 32'h0000aa00, rs);
        wstrb <= 4'hf;
        rd(`IOSM_A_SVC, v1, rs);
        chk("service byte strobe", 32'h0000aa64, v1);
        rd(`IOSM_A_PK_INT, v0, rs);
        chk("internal peak", 32'h0123, v0);
        rd(`IOSM_A_PK_HS, v0, rs);
        chk("heatsink peak", 32'h0456, v0);
        rd(`IOSM_A_PK_CUR, v0, rs);
        chk("current peak", 32'h0789, v0);
        // a lower level shows once the tracker restarts
        t_int <= 16'h0011;
        repeat (30) @(posedge aclk);
        rd(`IOSM_A_PK_INT, v0, rs);
        chk("internal peak restart", 32'h0011, v0);
        wr(`IOSM_A_CAP_REF, 32'hc8, rs);
        rd(`IOSM_A_CAP_REF, v0, rs);
        chk("cap reference", 32'hc8, v0);
        rd(`IOSM_A_CAP, v0, rs);
        chk("cap health", 32'h4b, v0);
        // reference equal to the measurement reads as full health
        wr(`IOSM_A_CAP_REF, 32'h96, rs);
        rd(`IOSM_A_CAP, v0, rs);
        chk("cap health full", 32'h64, v0);
        complete_run();
    end
endmodule
